/* verilog/pra_pkg.sv */
package pra_pkg;
  // Bit positions of the synchronised input vector
  localparam int SYNC_W = 5;
  localparam int BIT_SAMPLE = 0;
  localparam int BIT_SWITCH = 1;
  localparam int BIT_DATA = 2;
  localparam int BIT_ZERO = 3;
  localparam int BIT_PI = 4;
  // Clock and strobe timing
  localparam int CLK_HZ = 20_000_000;
  localparam int STROBE_RATE_HZ = 3200;
  localparam int STROBE_PERIOD_CYCLES = CLK_HZ / STROBE_RATE_HZ;
  localparam int STROBE_TIMEOUT_CYCLES = 2 * STROBE_PERIOD_CYCLES;
  localparam int GAP_W = 15;

  // Balanced pattern at zero input: runs of this many pulses per sign
  localparam int RUN_W = 3;
  localparam logic [RUN_W-1:0] BALANCED_RUN = 3'h3;
  localparam logic [RUN_W-1:0] RUN_MAX = 3'h7;

  // Values after reset; torque starts in the plus coil
  localparam logic TORQUE_RESET = 1'b1;
  localparam logic DIR_RESET = 1'b1;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 5'h00;

  // Velocity pulse buffer
  localparam int VEL_FIFO_W = 1;
  localparam int VEL_FIFO_DEPTH = 4;
endpackage : pra_pkg

/* verilog/pra_interface.sv */
`timescale 1ns/1ps
// Operation
// - sample strobe gates zero and pi phase
// - gated products set or reset direction flip-flop
// - switch strobe yields exactly one torque command
// - torque commands set torque flip-flop, repeats hold
// - torque state enables only its own coil
// - data strobe yields one up or down pulse
// - zero input gives three up, three down
// - reset forces torque flip-flop to plus coil
// - direction changes only during sample strobe

module pra_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wr;
    logic [AW:0] rd;
  } pra_fifo_state_t;

  pra_fifo_state_t q;
  pra_fifo_state_t d;
  logic full;
  logic empty;

  assign empty = (q.wr == q.rd);
  assign full = (q.wr[AW] != q.rd[AW]) && (q.wr[AW-1:0] == q.rd[AW-1:0]);
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = q.mem[q.rd[AW-1:0]];

  always_comb begin
    d = q;
    if (inValid && !full) begin
      d.mem[q.wr[AW-1:0]] = inData;
      d.wr = q.wr + 1'b1;
    end
    if (outReady && !empty) begin
      d.rd = q.rd + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : pra_fifo

module pra_interface #(
  parameter int STROBE_TIMEOUT = pra_pkg::STROBE_TIMEOUT_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sampleStrobe,
  input wire logic switchStrobe,
  input wire logic dataStrobe,
  input wire logic zeroPhaseIn,
  input wire logic piPhaseIn,
  output logic plusTorqueCommand,
  output logic minusTorqueCommand,
  output logic plusCoilEnable,
  output logic minusCoilEnable,
  output logic upPulse,
  output logic downPulse,
  output logic velValid,
  output logic velUp,
  input wire logic velReady,
  output logic droppedPulse,
  output logic strobeLost,
  output logic balancedPattern
);
  typedef struct packed {
    logic [pra_pkg::SYNC_W-1:0] sync1;
    logic [pra_pkg::SYNC_W-1:0] sync2;
    logic [pra_pkg::SYNC_W-1:0] sync3;
    logic [pra_pkg::SYNC_W-1:0] filt;
    logic dir;
    logic torque;
    logic plusCmd;
    logic minusCmd;
    logic up;
    logic down;
    logic pushPend;
    logic pushUp;
    logic dropped;
    logic [pra_pkg::GAP_W-1:0] gap;
    logic lost;
    logic [pra_pkg::RUN_W-1:0] runLen;
    logic runUp;
    logic prevRun3;
    logic balanced;
  } pra_state_t;

  localparam logic [pra_pkg::GAP_W-1:0] TIMEOUT_CNT = pra_pkg::GAP_W'(STROBE_TIMEOUT);

  pra_state_t q;
  pra_state_t d;
  logic [pra_pkg::SYNC_W-1:0] agree;
  logic [pra_pkg::SYNC_W-1:0] rise;
  logic sampleOn;
  logic zeroOn;
  logic piOn;
  logic swRise;
  logic dtRise;
  logic smpRise;
  logic fifoInReady;

  // A level counts only once the second and third stages agree
  assign agree = q.sync2 ~^ q.sync3;
  assign rise = agree & q.sync3 & ~q.filt;
  assign sampleOn = q.filt[pra_pkg::BIT_SAMPLE];
  assign zeroOn = q.filt[pra_pkg::BIT_ZERO];
  assign piOn = q.filt[pra_pkg::BIT_PI];
  assign smpRise = rise[pra_pkg::BIT_SAMPLE];
  assign swRise = rise[pra_pkg::BIT_SWITCH];
  assign dtRise = rise[pra_pkg::BIT_DATA];

  always_comb begin
    d = q;
    d.sync1 = {piPhaseIn, zeroPhaseIn, dataStrobe, switchStrobe, sampleStrobe};
    d.sync2 = q.sync1;
    d.sync3 = q.sync2;
    d.filt = (agree & q.sync3) | (~agree & q.filt);

    // Both thresholds high at once is noise: hold the direction
    if (sampleOn && zeroOn && !piOn) begin
      d.dir = 1'b1;
    end else if (sampleOn && piOn && !zeroOn) begin
      d.dir = 1'b0;
    end

    d.plusCmd = swRise && q.dir;
    d.minusCmd = swRise && !q.dir;

    if (q.plusCmd) begin
      d.torque = 1'b1;
    end else if (q.minusCmd) begin
      d.torque = 1'b0;
    end

    d.up = dtRise && q.torque;
    d.down = dtRise && !q.torque;

    // A word waits here while the buffer is full; a second one is lost
    d.dropped = dtRise && q.pushPend && !fifoInReady;
    if (q.pushPend && fifoInReady) begin
      d.pushPend = 1'b0;
    end
    if (dtRise && !(q.pushPend && !fifoInReady)) begin
      d.pushPend = 1'b1;
      d.pushUp = q.torque;
    end

    // Run lengths of equal-sign pulses; two runs of three mark balance
    if (dtRise) begin
      if (q.torque == q.runUp) begin
        if (q.runLen != pra_pkg::RUN_MAX) begin
          d.runLen = q.runLen + 1'b1;
        end
      end else begin
        d.balanced = (q.runLen == pra_pkg::BALANCED_RUN) && q.prevRun3;
        d.prevRun3 = (q.runLen == pra_pkg::BALANCED_RUN);
        d.runLen = 3'h1;
        d.runUp = q.torque;
      end
    end

    if (smpRise) begin
      d.gap = '0;
    end else if (q.gap != TIMEOUT_CNT) begin
      d.gap = q.gap + 1'b1;
    end
    d.lost = (d.gap == TIMEOUT_CNT);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= '0;
      q.sync1 <= pra_pkg::SYNC_RESET;
      q.sync2 <= pra_pkg::SYNC_RESET;
      q.sync3 <= pra_pkg::SYNC_RESET;
      q.filt <= pra_pkg::SYNC_RESET;
      q.dir <= pra_pkg::DIR_RESET;
      q.torque <= pra_pkg::TORQUE_RESET;
      q.runUp <= pra_pkg::TORQUE_RESET;
    end else begin
      q <= d;
    end
  end

  pra_fifo #(
    .WIDTH(pra_pkg::VEL_FIFO_W),
    .DEPTH(pra_pkg::VEL_FIFO_DEPTH)
  ) velFifo (
    .clk(clk),
    .resetn(resetn),
    .inValid(q.pushPend),
    .inReady(fifoInReady),
    .inData(q.pushUp),
    .outValid(velValid),
    .outReady(velReady),
    .outData(velUp)
  );

  assign plusTorqueCommand = q.plusCmd;
  assign minusTorqueCommand = q.minusCmd;
  assign plusCoilEnable = q.torque;
  assign minusCoilEnable = !q.torque;
  assign upPulse = q.up;
  assign downPulse = q.down;
  assign droppedPulse = q.dropped;
  assign strobeLost = q.lost;
  assign balancedPattern = q.balanced;

  sequence s_switchEdge;
    swRise;
  endsequence

  sequence s_oneCommand;
    (plusTorqueCommand ^ minusTorqueCommand);
  endsequence

  sequence s_dataEdge;
    dtRise;
  endsequence

  property p_dirPlus;
    @(posedge clk) disable iff (!resetn)
      (sampleOn && zeroOn && !piOn) |=> q.dir;
  endproperty
  a_dirPlus: assert property (p_dirPlus) else $error("zero phase did not set plus");

  property p_dirMinus;
    @(posedge clk) disable iff (!resetn)
      (sampleOn && piOn && !zeroOn) |=> !q.dir;
  endproperty
  a_dirMinus: assert property (p_dirMinus) else $error("pi phase did not set minus");

  property p_dirOnlyInSample;
    @(posedge clk) disable iff (!resetn)
      (q.dir != $past(q.dir)) |-> $past(sampleOn);
  endproperty
  a_dirOnlyInSample: assert property (p_dirOnlyInSample) else $error("dir moved w/o strobe");

  property p_oneCommand;
    @(posedge clk) disable iff (!resetn)
      s_switchEdge |=> s_oneCommand ##1 (!plusTorqueCommand && !minusTorqueCommand);
  endproperty
  a_oneCommand: assert property (p_oneCommand) else $error("not one torque command");

  property p_commandSign;
    @(posedge clk) disable iff (!resetn)
      plusTorqueCommand |-> $past(q.dir);
  endproperty
  a_commandSign: assert property (p_commandSign) else $error("command sign wrong");

  property p_torqueFollows;
    @(posedge clk) disable iff (!resetn)
      (plusTorqueCommand |=> plusCoilEnable) and (minusTorqueCommand |=> minusCoilEnable);
  endproperty
  a_torqueFollows: assert property (p_torqueFollows) else $error("torque ff missed cmd");

  property p_torqueHolds;
    @(posedge clk) disable iff (!resetn)
      (!plusTorqueCommand && !minusTorqueCommand) |=> $stable(plusCoilEnable);
  endproperty
  a_torqueHolds: assert property (p_torqueHolds) else $error("torque moved w/o cmd");

  property p_oneCoil;
    @(posedge clk) disable iff (!resetn)
      plusCoilEnable != minusCoilEnable;
  endproperty
  a_oneCoil: assert property (p_oneCoil) else $error("coil enables not exclusive");

  property p_velPulse;
    @(posedge clk) disable iff (!resetn)
      s_dataEdge |=> (upPulse == $past(plusCoilEnable)) && (downPulse == !$past(plusCoilEnable));
  endproperty
  a_velPulse: assert property (p_velPulse) else $error("velocity pulse wrong");

  property p_velOnlyOnData;
    @(posedge clk) disable iff (!resetn)
      (upPulse || downPulse) |-> $past(dtRise);
  endproperty
  a_velOnlyOnData: assert property (p_velOnlyOnData) else $error("stray velocity pulse");

  property p_balanced;
    @(posedge clk) disable iff (!resetn)
      $rose(balancedPattern) |-> $past(dtRise) && $past(q.runLen == pra_pkg::BALANCED_RUN);
  endproperty
  a_balanced: assert property (p_balanced) else $error("balance flag w/o 3-3");

  property p_resetPlus;
    @(posedge clk) !resetn |=> plusCoilEnable && !minusCoilEnable;
  endproperty
  a_resetPlus: assert property (p_resetPlus) else $error("reset left coil undefined");
endmodule : pra_interface

/* tb/pra_computer_model.sv */
`timescale 1ns/1ps
module pra_computer_model #(
  parameter int PERIOD = 400,
  parameter int CAP = 4
) (
  input wire logic clk,
  input wire logic run,
  input wire logic stall,
  output logic sampleStrobe,
  output logic switchStrobe,
  output logic dataStrobe,
  input wire logic velValid,
  input wire logic velUp,
  output logic velReady,
  output int incCount
);
  int t = 0;
  int acc = 0;
  // One phase counter feeds every strobe, so they never drift apart
  always @(posedge clk) begin
    t <= run ? (t + 1) % PERIOD : 0;
    sampleStrobe <= #1 run && t < 40;
    switchStrobe <= #1 run && t >= 60 && t < 120;
    dataStrobe <= #1 run && t >= 100 && t < 160;
    velReady <= #1 !stall;
    if (!run) begin
      acc <= 0;
    end else if (velValid === 1'b1 && velReady) begin
      // Forward on up, backward on down; overflow emits an increment
      if (velUp && acc == CAP) begin
        acc <= 0;
        incCount <= incCount + 1;
      end else if (!velUp && acc == -CAP) begin
        acc <= 0;
        incCount <= incCount - 1;
      end else begin
        acc <= velUp ? acc + 1 : acc - 1;
      end
    end
  end
endmodule : pra_computer_model

/* tb/pra_interface_tb.sv */
`timescale 1ns/1ps
module pra_interface_tb;
  logic clk = 1'b0, resetn = 1'b0, run = 1'b0, stall = 1'b0, zeroPhaseIn = 1'b1, piPhaseIn = 1'b0;
  logic sampleStrobe, switchStrobe, dataStrobe, velReady, velValid, velUp;
  logic plusTorqueCommand, minusTorqueCommand, plusCoilEnable, minusCoilEnable;
  logic upPulse, downPulse, droppedPulse, strobeLost, balancedPattern;
  int incCount, miscompares = 0, n_compared = 0;
  int nUp, nDn, nPc, nMc, nDrop;
  pra_computer_model pc_u (.clk(clk), .run(run), .stall(stall), .sampleStrobe(sampleStrobe),
    .switchStrobe(switchStrobe), .dataStrobe(dataStrobe), .velValid(velValid),
    .velUp(velUp), .velReady(velReady), .incCount(incCount));
  pra_interface #(.STROBE_TIMEOUT(1000)) dut_u (.clk(clk), .resetn(resetn),
    .sampleStrobe(sampleStrobe), .switchStrobe(switchStrobe), .dataStrobe(dataStrobe),
    .zeroPhaseIn(zeroPhaseIn), .piPhaseIn(piPhaseIn), .plusTorqueCommand(plusTorqueCommand),
    .minusTorqueCommand(minusTorqueCommand), .plusCoilEnable(plusCoilEnable),
    .minusCoilEnable(minusCoilEnable), .upPulse(upPulse), .downPulse(downPulse),
    .velValid(velValid), .velUp(velUp), .velReady(velReady), .droppedPulse(droppedPulse),
    .strobeLost(strobeLost), .balancedPattern(balancedPattern));
  initial forever #25 clk = ~clk;
  always @(posedge clk) begin
    nUp += (upPulse === 1'b1);
    nDn += (downPulse === 1'b1);
    nPc += (plusTorqueCommand === 1'b1);
    nMc += (minusTorqueCommand === 1'b1);
    nDrop += (droppedPulse === 1'b1);
  end
  task automatic chk(input bit ok, input string m);
    n_compared++;
    if (!ok) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic stop_test;
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  // One strobe period with phases z/p; f flips both phases once the sample strobe is over
  task automatic per(input logic z, input logic p, input logic e, input bit f);
    @(posedge clk);
    #1;
    zeroPhaseIn = z;
    piPhaseIn = p;
    nUp = 0;
    nDn = 0;
    nPc = 0;
    nMc = 0;
    if (f) begin
      @(negedge sampleStrobe);
      @(posedge clk);
      #1;
      zeroPhaseIn = !z;
      piPhaseIn = !p;
    end
    @(negedge dataStrobe);
    repeat (3) @(posedge clk);
    #1;
    chk(nPc == e && nMc == !e, "torque command count");
    chk(plusCoilEnable === e && minusCoilEnable === !e, "coil enable");
    chk(nUp == e && nDn == !e, "velocity pulse count");
  endtask : per
  task automatic t_reset;
    chk(plusCoilEnable === 1'b1 && minusCoilEnable === 1'b0, "reset coil");
    chk(velValid === 1'b0 && strobeLost === 1'b0, "reset flags");
  endtask : t_reset
  task automatic t_balanced;
    run = 1'b1;
    for (int k = 0; k < 12; k++) per(k % 6 < 3, k % 6 >= 3, k % 6 < 3, 0);
    chk(balancedPattern === 1'b1, "balanced flag");
    chk(incCount == 0, "no increment when balanced");
  endtask : t_balanced
  task automatic t_unbalanced;
    for (int k = 0; k < 5; k++) per(1, 0, 1, 0);
    repeat (5) @(posedge clk);
    chk(incCount == 1, "plus increment");
  endtask : t_unbalanced
  task automatic t_hold;
    per(1, 1, 1, 0);
    per(0, 1, 0, 0);
    chk(balancedPattern === 1'b0, "balance cleared");
    per(1, 1, 0, 0);
    per(1, 0, 1, 0);
    per(0, 1, 0, 1);
  endtask : t_hold
  task automatic t_fifo;
    stall = 1'b1;
    nDrop = 0;
    for (int k = 0; k < 6; k++) per(1, 0, 1, 0);
    chk(velValid === 1'b1 && velUp === 1'b1 && nDrop == 1, "fifo full drop");
    @(posedge clk);
    #1;
    stall = 1'b0;
    repeat (10) @(posedge clk);
    chk(velValid === 1'b0, "fifo drained");
  endtask : t_fifo
  task automatic t_lost;
    @(posedge clk);
    #1;
    run = 1'b0;
    repeat (1100) @(posedge clk);
    #1;
    chk(strobeLost === 1'b1, "strobe lost");
    run = 1'b1;
    per(1, 0, 1, 0);
    chk(strobeLost === 1'b0, "strobe back");
  endtask : t_lost
  initial begin
    repeat (10) @(posedge clk);
    #1;
    resetn = 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_balanced();
    t_unbalanced();
    t_hold();
    t_fifo();
    t_lost();
    stop_test();
  end
  // About 12000 cycles of work; the limit leaves wide margin
  initial begin
    #1_500_000;
    miscompares++;
    stop_test();
  end
endmodule : pra_interface_tb
